// File: pmu_gate_pkg.sv
// Shared constants and types for the debug-gated performance counter block
`default_nettype none
package pmu_gate_pkg;

  // Register byte offsets
  localparam logic [11:0] CTRL_OFFSET     = 12'h000;
  localparam logic [11:0] CNT_EN_OFFSET   = 12'h004;
  localparam logic [11:0] STATUS_OFFSET   = 12'h008;
  localparam logic [11:0] MASK_OFFSET     = 12'h00C;
  localparam logic [11:0] AUTH_OFFSET     = 12'h010;
  localparam logic [11:0] CYC_OFFSET      = 12'h020;
  localparam logic [11:0] CYC_SNAP_OFFSET = 12'h024;
  localparam logic [3:0]  EVCNT_PAGE      = 4'h1;
  localparam logic [3:0]  EVSNAP_PAGE     = 4'h2;

  // Control register fields
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_CLEAR_BIT  = 1;
  localparam int CTRL_EXPORT_BIT = 2;

  // Status, mask and counter enable share one layout
  localparam int CYC_BIT       = 31;
  localparam int SNAP_DONE_BIT = 30;

  // Auth status fields
  localparam int AUTH_NS_BIT  = 4;
  localparam int AUTH_S_BIT   = 5;
  localparam int AUTH_ACK_BIT = 8;
  localparam int AUTH_REQ_BIT = 9;

  // Values after reset
  localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;
  localparam logic [31:0] CNT_EN_RESET = 32'h0000_0000;
  localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
  localparam logic [31:0] MASK_RESET   = 32'h0000_0000;

  typedef struct packed {
    logic noninvasive_dbg_en;
    logic secure_noninvasive_dbg_en;
    logic invasive_dbg_en;
    logic secure_invasive_dbg_en;
  } dbg_auth_type;

  typedef struct packed {
    logic        sel;
    logic        enable;
    logic        write;
    logic [11:0] addr;
    logic [31:0] wdata;
    logic [3:0]  strb;
  } apb_req_type;

  // Snapshot handshake, Gray coded along idle, capture, acknowledge
  typedef enum logic [1:0] {
    SNAP_IDLE    = 2'b00,
    SNAP_CAPTURE = 2'b01,
    SNAP_ACK     = 2'b11
  } snap_state_type;

endpackage : pmu_gate_pkg
`default_nettype wire

// File: counter_slice.sv
// One wrapping counter with clear and a registered wrap pulse
`default_nettype none
module counter_slice #(
  parameter int WIDTH = 32
) (
  input  wire logic             mclk,    // Clock
  input  wire logic             sys_rst, // Synchronous reset
  input  wire logic             clear,   // Return to zero
  input  wire logic             inc,     // Count one
  output logic [WIDTH-1:0]      value,   // Current count
  output logic                  wrap     // One-cycle pulse after rollover
);

  typedef struct packed {
    logic [WIDTH-1:0] value;
    logic             wrap;
  } state_type;

  state_type s_q;
  state_type s_d;

  always_comb begin
    s_d      = s_q;
    s_d.wrap = 1'b0;
    if (clear) begin
      s_d.value = '0;
    end else if (inc) begin
      s_d.value = s_q.value + {{(WIDTH-1){1'b0}}, 1'b1};
      s_d.wrap  = &s_q.value;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign value = s_q.value;
  assign wrap  = s_q.wrap;

endmodule : counter_slice
`default_nettype wire

// File: pmu_debug_gating_snapshot.sv
// Debug-gated event counters with snapshot handshake, overflow interrupt and APB registers
//
// Contract
// [RQ1] Non-invasive enable permits counting and export
// [RQ2] Invasive enable permits counting and export
// [RQ3] Secure counting needs secure and non-invasive enables
// [RQ4] Secure counting needs secure and invasive enables
// [RQ5] Requester raises request, four-phase with acknowledge
// [RQ6] Acknowledge rises after counters are captured
// [RQ7] Overflow drives active-low interrupt level
// [RQ8] Acknowledge held until request falls
//
// Implementation choices: the APB slave port and the address map.
`default_nettype none
module pmu_debug_gating_snapshot #(
  parameter int NUM_CNT   = 4,  // Event counters, at most 30
  parameter int CNT_WIDTH = 32  // Counter width, at most 32
) (
  input  wire logic               mclk,                      // Clock, 125 MHz
  input  wire logic               sys_rst,                   // Synchronous reset, high
  input  wire logic               noninvasive_dbg_en,        // Non-invasive debug enable
  input  wire logic               secure_noninvasive_dbg_en, // Secure non-invasive enable
  input  wire logic               invasive_dbg_en,           // Invasive debug enable
  input  wire logic               secure_invasive_dbg_en,    // Secure invasive enable
  input  wire logic [NUM_CNT-1:0] event_pulse,               // Event occurrences, one per counter
  input  wire logic [NUM_CNT-1:0] event_secure,              // Event belongs to Secure state
  output logic      [NUM_CNT-1:0] event_export,              // Exported permitted events
  output logic      [NUM_CNT-1:0] event_export_secure,       // Secure attribute of exports
  input  wire logic               counter_snapshot_req,      // Snapshot request
  output logic                    counter_snapshot_ack,      // Snapshot acknowledge
  output logic                    counter_overflow_irq_n,    // Overflow interrupt, low
  output logic                    irq,                       // Masked status interrupt, high
  input  wire logic               psel,                      // APB select
  input  wire logic               penable,                   // APB enable
  input  wire logic               pwrite,                    // APB direction
  input  wire logic [11:0]        paddr,                     // APB byte address
  input  wire logic [31:0]        pwdata,                    // APB write data
  input  wire logic [3:0]         pstrb,                     // APB byte strobes
  output logic [31:0]             prdata,                    // APB read data
  output logic                    pready,                    // APB ready
  output logic                    pslverr                    // APB error
);

  localparam int NCNT = NUM_CNT + 1;

  typedef struct packed {
    logic                           enable;
    logic                           clear;
    logic                           export_en;
    logic [31:0]                    cnt_en;
    logic [31:0]                    status;
    logic [31:0]                    mask;
    pmu_gate_pkg::snap_state_type   snap;
    logic                           ack;
    logic [NCNT-1:0][CNT_WIDTH-1:0] snap_val;
    logic [NUM_CNT-1:0]             export_ev;
    logic [NUM_CNT-1:0]             export_sec;
    logic [31:0]                    rdata;
    logic                           err;
    logic                           irq;
    logic                           irq_n;
  } state_type;

  state_type                      s_q;
  state_type                      s_d;
  pmu_gate_pkg::dbg_auth_type     auth;
  pmu_gate_pkg::apb_req_type      req;
  logic [NCNT-1:0][CNT_WIDTH-1:0] cnt_val;
  logic [NCNT-1:0]                cnt_wrap;
  logic [NCNT-1:0]                cnt_inc;
  logic                           ns_allow;
  logic                           s_allow;
  logic [NUM_CNT-1:0]             ev_allow;
  logic [31:0]                    valid_bits;
  logic [31:0]                    ovf_bits;

  assign auth = '{noninvasive_dbg_en:        noninvasive_dbg_en,
                  secure_noninvasive_dbg_en: secure_noninvasive_dbg_en,
                  invasive_dbg_en:           invasive_dbg_en,
                  secure_invasive_dbg_en:    secure_invasive_dbg_en};
  assign req  = '{sel: psel, enable: penable, write: pwrite, addr: paddr, wdata: pwdata, strb: pstrb};

  // [RQ1] Non-invasive path
  // [RQ2] Invasive path
  assign ns_allow = auth.noninvasive_dbg_en | auth.invasive_dbg_en;
  // [RQ3] Secure non-invasive pair
  // [RQ4] Secure invasive pair
  assign s_allow  = (auth.secure_noninvasive_dbg_en & auth.noninvasive_dbg_en) |
                    (auth.secure_invasive_dbg_en & auth.invasive_dbg_en);

  always_comb begin
    for (int i = 0; i < NUM_CNT; i++) begin
      ev_allow[i] = event_pulse[i] & (event_secure[i] ? s_allow : ns_allow);
      cnt_inc[i]  = s_q.enable & s_q.cnt_en[i] & ev_allow[i];
    end
    // Cycle counter runs while CTRL enable and CNT_EN bit 31 are set and the non-invasive or invasive debug enable is set
    cnt_inc[NUM_CNT] = s_q.enable & s_q.cnt_en[pmu_gate_pkg::CYC_BIT] & ns_allow;
  end

  genvar g;
  generate
    for (g = 0; g < NCNT; g++) begin : gen_cnt
      counter_slice #(
        .WIDTH (CNT_WIDTH)
      ) u_cnt (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .clear   (s_q.clear),
        .inc     (cnt_inc[g]),
        .value   (cnt_val[g]),
        .wrap    (cnt_wrap[g])
      );
    end
  endgenerate

  always_comb begin
    ovf_bits = 32'h0000_0000;
    ovf_bits[NUM_CNT-1:0] = cnt_wrap[NUM_CNT-1:0];
    ovf_bits[pmu_gate_pkg::CYC_BIT] = cnt_wrap[NUM_CNT];
    valid_bits = 32'h0000_0000;
    valid_bits[NUM_CNT-1:0] = '1;
    valid_bits[pmu_gate_pkg::CYC_BIT] = 1'b1;
    valid_bits[pmu_gate_pkg::SNAP_DONE_BIT] = 1'b1;
  end

  function automatic logic [31:0] merge_strb(input logic [31:0] old_val,
                                             input logic [31:0] new_val,
                                             input logic [3:0]  strb);
    logic [31:0] res;
    res = old_val;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = new_val[8*b +: 8];
      end
    end
    return res;
  endfunction : merge_strb

  function automatic logic [31:0] widen(input logic [CNT_WIDTH-1:0] v);
    logic [31:0] res;
    res = 32'h0000_0000;
    res[CNT_WIDTH-1:0] = v;
    return res;
  endfunction : widen

  logic        setup_rd;
  logic        access_wr;
  logic [5:0]  word_idx;
  logic        idx_ok;
  logic [31:0] rd_mux;
  logic        rd_err;
  logic [31:0] wr_val;
  logic [31:0] clr_bits;
  logic [31:0] set_bits;
  logic        wr_err;

  assign setup_rd  = req.sel & ~req.enable & ~req.write;
  assign access_wr = req.sel & req.enable & req.write;
  assign word_idx  = req.addr[7:2];
  assign idx_ok    = int'(word_idx) < NUM_CNT;

  // Read decode, sampled in the setup cycle so data is registered for the access
  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_err = 1'b0;
    if (req.addr[11:8] == pmu_gate_pkg::EVCNT_PAGE && idx_ok) begin
      rd_mux = widen(cnt_val[word_idx]);
    end else if (req.addr[11:8] == pmu_gate_pkg::EVSNAP_PAGE && idx_ok) begin
      rd_mux = widen(s_q.snap_val[word_idx]);
    end else begin
      case (req.addr)
        pmu_gate_pkg::CTRL_OFFSET: begin
          rd_mux[pmu_gate_pkg::CTRL_ENABLE_BIT] = s_q.enable;
          rd_mux[pmu_gate_pkg::CTRL_EXPORT_BIT] = s_q.export_en;
        end
        pmu_gate_pkg::CNT_EN_OFFSET: rd_mux = s_q.cnt_en;
        pmu_gate_pkg::STATUS_OFFSET: rd_mux = s_q.status;
        pmu_gate_pkg::MASK_OFFSET:   rd_mux = s_q.mask;
        pmu_gate_pkg::AUTH_OFFSET: begin
          rd_mux[3:0] = auth;
          rd_mux[pmu_gate_pkg::AUTH_NS_BIT]  = ns_allow;
          rd_mux[pmu_gate_pkg::AUTH_S_BIT]   = s_allow;
          rd_mux[pmu_gate_pkg::AUTH_ACK_BIT] = s_q.ack;
          rd_mux[pmu_gate_pkg::AUTH_REQ_BIT] = counter_snapshot_req;
        end
        pmu_gate_pkg::CYC_OFFSET:      rd_mux = widen(cnt_val[NUM_CNT]);
        pmu_gate_pkg::CYC_SNAP_OFFSET: rd_mux = widen(s_q.snap_val[NUM_CNT]);
        default: rd_err = 1'b1;
      endcase
    end
  end

  // Write decode, effective at the access edge
  always_comb begin
    wr_val   = merge_strb(32'h0000_0000, req.wdata, req.strb);
    clr_bits = 32'h0000_0000;
    wr_err   = 1'b0;
    case (req.addr)
      pmu_gate_pkg::CTRL_OFFSET,
      pmu_gate_pkg::CNT_EN_OFFSET,
      pmu_gate_pkg::MASK_OFFSET: wr_err = 1'b0;
      pmu_gate_pkg::STATUS_OFFSET: clr_bits = wr_val & valid_bits;
      default: wr_err = 1'b1;
    endcase
    if (!access_wr) begin
      clr_bits = 32'h0000_0000;
    end
  end

  always_comb begin
    s_d       = s_q;
    s_d.clear = 1'b0;
    set_bits  = ovf_bits;

    // [RQ5] Four-phase snapshot sequence
    case (s_q.snap)
      pmu_gate_pkg::SNAP_IDLE: begin
        s_d.ack = 1'b0;
        if (counter_snapshot_req) begin
          s_d.snap = pmu_gate_pkg::SNAP_CAPTURE;
        end
      end
      pmu_gate_pkg::SNAP_CAPTURE: begin
        // [RQ6] Capture then acknowledge
        s_d.snap_val = cnt_val;
        s_d.ack      = 1'b1;
        s_d.snap     = pmu_gate_pkg::SNAP_ACK;
        set_bits[pmu_gate_pkg::SNAP_DONE_BIT] = 1'b1;
      end
      pmu_gate_pkg::SNAP_ACK: begin
        // [RQ8] Hold until request falls
        if (!counter_snapshot_req) begin
          s_d.ack  = 1'b0;
          s_d.snap = pmu_gate_pkg::SNAP_IDLE;
        end
      end
      default: begin
        s_d.ack  = 1'b0;
        s_d.snap = pmu_gate_pkg::SNAP_IDLE;
      end
    endcase

    if (access_wr) begin
      case (req.addr)
        pmu_gate_pkg::CTRL_OFFSET: begin
          if (req.strb[0]) begin
            s_d.enable    = req.wdata[pmu_gate_pkg::CTRL_ENABLE_BIT];
            s_d.clear     = req.wdata[pmu_gate_pkg::CTRL_CLEAR_BIT];
            s_d.export_en = req.wdata[pmu_gate_pkg::CTRL_EXPORT_BIT];
          end
        end
        pmu_gate_pkg::CNT_EN_OFFSET: s_d.cnt_en = merge_strb(s_q.cnt_en, req.wdata, req.strb) & valid_bits;
        pmu_gate_pkg::MASK_OFFSET:   s_d.mask   = merge_strb(s_q.mask, req.wdata, req.strb) & valid_bits;
        default: s_d.err = s_q.err;
      endcase
    end

    // Hardware set wins over a write-one clear in the same cycle
    s_d.status = ((s_q.status & ~clr_bits) | set_bits) & valid_bits;

    // [RQ1] Export gated by permission and export enable
    for (int i = 0; i < NUM_CNT; i++) begin
      s_d.export_ev[i]  = s_q.export_en & ev_allow[i];
      s_d.export_sec[i] = s_q.export_en & ev_allow[i] & event_secure[i];
    end

    if (setup_rd) begin
      s_d.rdata = rd_mux;
      s_d.err   = rd_err;
    end else if (req.sel & ~req.enable) begin
      s_d.rdata = 32'h0000_0000;
      s_d.err   = wr_err;
    end

    // New mask takes effect at the same edge as the status it gates
    s_d.irq   = |(s_d.status & s_d.mask);
    // [RQ7] Low while any overflow is pending
    s_d.irq_n = ~|(s_d.status & ~(32'h0000_0001 << pmu_gate_pkg::SNAP_DONE_BIT));
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s_q           <= '0;
      s_q.enable    <= pmu_gate_pkg::CTRL_RESET[pmu_gate_pkg::CTRL_ENABLE_BIT];
      s_q.export_en <= pmu_gate_pkg::CTRL_RESET[pmu_gate_pkg::CTRL_EXPORT_BIT];
      s_q.cnt_en    <= pmu_gate_pkg::CNT_EN_RESET;
      s_q.status    <= pmu_gate_pkg::STATUS_RESET;
      s_q.mask      <= pmu_gate_pkg::MASK_RESET;
      s_q.snap      <= pmu_gate_pkg::SNAP_IDLE;
      s_q.irq_n     <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign event_export           = s_q.export_ev;
  assign event_export_secure    = s_q.export_sec;
  assign counter_snapshot_ack   = s_q.ack;
  assign counter_overflow_irq_n = s_q.irq_n;
  assign irq                    = s_q.irq;
  assign prdata                 = s_q.rdata;
  assign pready                 = 1'b1;
  assign pslverr                = req.sel & req.enable & s_q.err;

endmodule : pmu_debug_gating_snapshot
`default_nettype wire

// File: pmu_gate_props.sv
// Port-level checks for the debug-gated counter block
`default_nettype none
module pmu_gate_props #(
  parameter int NUM_CNT = 4
) (
  input wire logic               mclk,                      // Clock
  input wire logic               sys_rst,                   // Reset
  input wire logic               noninvasive_dbg_en,        // Auth
  input wire logic               secure_noninvasive_dbg_en, // Auth
  input wire logic               invasive_dbg_en,           // Auth
  input wire logic               secure_invasive_dbg_en,    // Auth
  input wire logic [NUM_CNT-1:0] event_pulse,               // Events
  input wire logic [NUM_CNT-1:0] event_export,              // Exports
  input wire logic [NUM_CNT-1:0] event_export_secure,       // Secure exports
  input wire logic               counter_snapshot_req,      // Request
  input wire logic               counter_snapshot_ack,      // Acknowledge
  input wire logic               counter_overflow_irq_n,    // Overflow
  input wire logic               psel,                      // APB
  input wire logic               penable,                   // APB
  input wire logic               pwrite,                    // APB
  input wire logic [11:0]        paddr,                     // APB
  input wire logic               pslverr                    // APB
);
  wire logic ns_ok = noninvasive_dbg_en || invasive_dbg_en;
  wire logic s_ok  = (secure_noninvasive_dbg_en && noninvasive_dbg_en) || (secure_invasive_dbg_en && invasive_dbg_en);
  wire logic st_wr = psel && penable && pwrite && (paddr == pmu_gate_pkg::STATUS_OFFSET);
  wire logic req   = counter_snapshot_req;
  wire logic ack   = counter_snapshot_ack;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  sequence ack_late;
    ##1 !ack ##1 ack;
  endsequence
  a_export_cause: assert property (event_export != '0 |-> $past(ns_ok)
    && ((event_export & ~$past(event_pulse)) == '0)) else $error("export without permitted event");
  a_secure_cause: assert property (event_export_secure != '0 |-> $past(s_ok))
    else $error("secure export without secure permission");
  a_ack_rise: assert property ($rose(req) && !ack |-> ack_late)
    else $error("acknowledge not two edges after request");
  a_ack_hold: assert property (ack && req |=> ack)
    else $error("acknowledge fell while request high");
  a_ack_drop: assert property (ack && !req |=> !ack)
    else $error("acknowledge stayed after request fell");
  a_ack_quiet: assert property (!ack && !req |=> !ack)
    else $error("acknowledge without request");
  a_irq_sticky: assert property (!counter_overflow_irq_n && !st_wr |=> !counter_overflow_irq_n)
    else $error("overflow interrupt released without clear");
  a_slverr_phase: assert property (pslverr |-> psel && penable)
    else $error("error outside access phase");
endmodule : pmu_gate_props
bind pmu_debug_gating_snapshot pmu_gate_props #(.NUM_CNT(NUM_CNT)) pmu_gate_props_i (
  .mclk(mclk), .sys_rst(sys_rst), .noninvasive_dbg_en(noninvasive_dbg_en),
  .secure_noninvasive_dbg_en(secure_noninvasive_dbg_en), .invasive_dbg_en(invasive_dbg_en),
  .secure_invasive_dbg_en(secure_invasive_dbg_en), .event_pulse(event_pulse), .event_export(event_export),
  .event_export_secure(event_export_secure), .counter_snapshot_req(counter_snapshot_req),
  .counter_snapshot_ack(counter_snapshot_ack), .counter_overflow_irq_n(counter_overflow_irq_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pslverr(pslverr));
`default_nettype wire

// File: snap_requester.sv
// Snapshot requester model for the four-phase capture handshake
`default_nettype none
module snap_requester (
  input  wire logic mclk,    // Clock
  input  wire logic sys_rst, // Reset
  input  wire logic go,      // Start one snapshot
  input  wire logic slow,    // Linger before lowering
  input  wire logic ack,     // Acknowledge
  output var  logic req,     // Request
  output var  logic done     // Handshake over
);
  logic [2:0] wait_q;
  logic       low_q;
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      req    <= 1'h0;
      done   <= 1'h0;
      low_q  <= 1'h0;
      wait_q <= 3'h0;
    end else begin
      done <= 1'h0;
      if (go && !req && !ack) begin
        req <= 1'h1;
      end
      if (req && ack) begin
        wait_q <= wait_q + 3'h1;
        if (!slow || wait_q == 3'h5) begin
          req    <= 1'h0;
          low_q  <= 1'h1;
          wait_q <= 3'h0;
        end
      end
      if (low_q && !ack) begin
        low_q <= 1'h0;
        done  <= 1'h1;
      end
    end
  end
endmodule : snap_requester
`default_nettype wire

// File: pmu_debug_gating_snapshot_tb_top.sv
// Self-checking bench for the debug-gated counter block
`default_nettype none
module pmu_debug_gating_snapshot_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int N = 4;
  pmu_gate_pkg::dbg_auth_type auth = '0;
  logic         mclk = 0, sys_rst = 1, go = 0, slow = 0, psel = 0, penable = 0, pwrite = 0;
  logic [N-1:0] ev = '0, sec = '0, exp_o, exps_o, p, ps;
  logic         req, ack, irq_n, irq, done, pready, pslverr, err;
  logic [11:0]  paddr = '0;
  logic [31:0]  pwdata = '0, prdata, rd, st = '0;
  int           bad_count = 0, comparisons = 0, cnt[N] = '{default: 0};
  always #4 mclk = ~mclk;
  pmu_debug_gating_snapshot #(.NUM_CNT(N), .CNT_WIDTH(4)) pmu_debug_gating_snapshot_i (
    .mclk(mclk), .sys_rst(sys_rst), .noninvasive_dbg_en(auth.noninvasive_dbg_en),
    .secure_noninvasive_dbg_en(auth.secure_noninvasive_dbg_en), .invasive_dbg_en(auth.invasive_dbg_en),
    .secure_invasive_dbg_en(auth.secure_invasive_dbg_en), .event_pulse(ev), .event_secure(sec),
    .event_export(exp_o), .event_export_secure(exps_o), .counter_snapshot_req(req),
    .counter_snapshot_ack(ack), .counter_overflow_irq_n(irq_n), .irq(irq), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  snap_requester snap_requester_i (.mclk(mclk), .sys_rst(sys_rst), .go(go), .slow(slow), .ack(ack),
    .req(req), .done(done));
  task automatic check(input logic [31:0] got, input logic [31:0] want);
    comparisons++;
    if (got !== want) begin
      bad_count++;
      $display("BAD t=%0t got=%h want=%h", $time, got, want);
    end
  endtask : check
  task automatic wrap_up;
    $display("mismatches=%0d comparisons=%0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : wrap_up
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    psel   <= 1'h1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'h1;
    for (k = 0; k < 20; k++) begin
      @(posedge mclk);
      if (pready === 1'h1) break;
    end
    if (k == 20) begin
      bad_count++;
      wrap_up();
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
    @(posedge mclk);
  endtask : apb
  task automatic rdchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] want, input logic e);
    apb(1'h0, a, 32'h0000_0000);
    check(rd & m, want);
    check(err, e);
  endtask : rdchk
  initial begin
    int i, j, k;
    void'($urandom(32'hcbe0_6ad2));
    repeat (10) @(posedge mclk);
    sys_rst <= 1'h0;
    @(posedge mclk);
    rdchk(pmu_gate_pkg::CTRL_OFFSET, 32'hffff_ffff, pmu_gate_pkg::CTRL_RESET, 1'h0);
    rdchk(pmu_gate_pkg::MASK_OFFSET, 32'hffff_ffff, pmu_gate_pkg::MASK_RESET, 1'h0);
    rdchk(12'hffc, 32'hffff_ffff, 32'h0000_0000, 1'h1);
    apb(1'h1, pmu_gate_pkg::AUTH_OFFSET, 32'hffff_ffff);
    check(err, 1'h1);
    apb(1'h1, pmu_gate_pkg::CTRL_OFFSET, 32'h0000_0005);
    apb(1'h1, pmu_gate_pkg::CNT_EN_OFFSET, 32'h0000_000f);
    // Random auth and events, exports checked one edge later
    for (i = 0; i < 400; i++) begin
      auth <= 4'($urandom);
      ev   <= N'($urandom);
      sec  <= N'($urandom);
      @(negedge mclk);
      if (i > 0) check(exp_o, p | ps);
      if (i > 0) check(exps_o, ps);
      p  = ev & ~sec & {N{auth.noninvasive_dbg_en | auth.invasive_dbg_en}};
      ps = ev & sec & {N{(auth.secure_noninvasive_dbg_en & auth.noninvasive_dbg_en)
        | (auth.secure_invasive_dbg_en & auth.invasive_dbg_en)}};
      for (j = 0; j < N; j++) begin
        cnt[j] = cnt[j] + int'(p[j] | ps[j]);
        if (cnt[j] == 16) st[j] = 1'h1;
        cnt[j] = cnt[j] % 16;
      end
      @(posedge mclk);
    end
    ev <= '0;
    // Full permission so the later non-secure bursts on counter 0 always count
    auth <= 4'hf;
    sec  <= '0;
    repeat (3) @(posedge mclk);
    for (j = 0; j < N; j++) rdchk(12'h100 + 12'(4 * j), 32'h0000_000f, cnt[j], 1'h0);
    check(irq_n, st[3:0] == 4'h0);
    rdchk(pmu_gate_pkg::STATUS_OFFSET, 32'h4000_000f, st, 1'h0);
    apb(1'h1, pmu_gate_pkg::MASK_OFFSET, 32'h4000_000f);
    check(irq, st[3:0] != 4'h0);
    apb(1'h1, pmu_gate_pkg::MASK_OFFSET, 32'h4000_0000);
    check(irq, 1'h0);
    apb(1'h1, pmu_gate_pkg::STATUS_OFFSET, 32'h0000_000f);
    check(irq_n, 1'h1);
    // Prompt then slow snapshot, counts moved in between
    for (i = 0; i < 2; i++) begin
      slow <= i[0];
      go   <= 1'h1;
      @(posedge mclk);
      go <= 1'h0;
      for (k = 0; k < 40 && done !== 1'h1; k++) @(posedge mclk);
      if (k == 40) begin
        bad_count++;
        wrap_up();
      end
      @(posedge mclk);
      for (j = 0; j < N; j++) rdchk(12'h200 + 12'(4 * j), 32'h0000_000f, cnt[j], 1'h0);
      check(irq, 1'h1);
      apb(1'h1, pmu_gate_pkg::STATUS_OFFSET, 32'h4000_000f);
      check(irq, 1'h0);
      ev <= 4'h1;
      repeat (3) @(posedge mclk);
      ev <= '0;
      cnt[0] = (cnt[0] + 3) % 16;
      @(posedge mclk);
    end
    wrap_up();
  end
endmodule : pmu_debug_gating_snapshot_tb_top
`default_nettype wire
